/* core/twt_consts.vh */
`ifndef TWT_CONSTS_VH
`define TWT_CONSTS_VH

// Register byte offsets
`define TWT_OFS_COMP0_CTRL    12'h028
`define TWT_OFS_COMP1_CTRL    12'h038
`define TWT_OFS_TRIG_CTRL     12'h200
`define TWT_OFS_MASTER_CTRL   12'h204
`define TWT_OFS_IRQ_STATUS    12'h208
`define TWT_OFS_IRQ_MASK      12'h20c
`define TWT_ADDR_W            12

// Comparator control fields
`define TWT_FN_LSB            0
`define TWT_FN_MSB            3
`define TWT_VON_BIT           8
`define TWT_SIZE_LSB          10
`define TWT_SIZE_MSB          11
`define TWT_LINK_LSB          12
`define TWT_LINK_MSB          15
`define TWT_HIT_BIT           24

// Match action encodings
`define TWT_FN_OFF            4'h0
`define TWT_FN_FETCH          4'h4
`define TWT_FN_READ           4'h5
`define TWT_FN_WRITE          4'h6
`define TWT_FN_RW             4'h7

// Trigger control fields
`define TWT_ACT0_BIT          0
`define TWT_ACT1_BIT          1
`define TWT_NCOMP_LSB         28
`define TWT_NCOMP_MSB         31
`define TWT_NCOMP_VAL         4'h2

// Master control fields
`define TWT_STARTEN_BIT       0
`define TWT_STOPEN_BIT        1
`define TWT_REC_BIT           2

// Interrupt status / mask fields
`define TWT_IRQ_W             4
`define TWT_IRQ_HIT0          0
`define TWT_IRQ_HIT1          1
`define TWT_IRQ_START         2
`define TWT_IRQ_STOP          3

// Reset values
`define TWT_RST_FN            4'h0
`define TWT_RST_SIZE          2'h0
`define TWT_RST_LINK          4'h0
`define TWT_RST_IRQ           4'h0

`endif

/* core/twt_trigger.v */
// Summary of operation
// - Comparator-1 bits 12, 11:10 and 8 read zero and ignore writes.
// - Hit flag sets on selected operation; a read of its register that returns it set clears it.
// - Comparator-1 bits 31-25 and 23-4 are read-only zero.
// - Action codes: 0000 off, 0100 fetch, 0101 read, 0110 write, 0111 either.
// - Start wins over stop when both pulses come together.
// - Start and stop pulses act only when their enable bits are set.
// - Trigger control reports two comparators in a read-only field.
// - Comparator-1 action bit: 0 gives stop pulse, 1 gives start pulse.
// - Comparator-0 action bit cleared gives stop pulse on comparator-0 hit.
// - Comparator-0 hits on address, data alone, or data plus comparator-1 address.
// - Comparator-1 hit means address fired; recording changes as action selects.
// - Comparator-0 size field: 00 byte, 01 halfword, 10 word, 11 reserved.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`include "twt_consts.vh"

module twt_trigger
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  // Core bus activity, one cycle per observed access
  input  wire        access_valid_i,
  input  wire        access_fetch_i,
  input  wire        access_read_i,
  input  wire        access_write_i,
  // Comparator datapath results
  input  wire        addr0_match_i,
  input  wire        data0_match_i,
  input  wire        addr1_match_i,
  // Comparator-0 setup for the datapath
  output reg         value_compare_on_o,
  output reg  [1:0]  value_compare_size_o,
  output reg  [3:0]  linked_address_comparator_o,
  // Trace buffer control
  output reg         trace_start_pulse_o,
  output reg         trace_stop_pulse_o,
  output reg         trace_recording_o,
  // Interrupt
  output wire        irq_o
);

  // Decode of the match action selector against the access type
  function func_hit;
    input [3:0] fn;
    input       fetch;
    input       rd;
    input       wr;
    begin
      case (fn)
        `TWT_FN_FETCH: func_hit = fetch;
        `TWT_FN_READ:  func_hit = rd;
        `TWT_FN_WRITE: func_hit = wr;
        `TWT_FN_RW:    func_hit = rd | wr;
        default:       func_hit = 1'b0;
      endcase
    end
  endfunction

  // Full 12-bit match, so no register shows up again at an alias
  function ofs_match;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      ofs_match = (addr == ofs);
    end
  endfunction

  // Register state
  reg  [3:0]            fn0;
  reg  [3:0]            fn1;
  reg                   hit0;
  reg                   hit1;
  reg                   act0;
  reg                   act1;
  reg                   start_en;
  reg                   stop_en;
  reg  [`TWT_IRQ_W-1:0] irq_status;
  reg  [`TWT_IRQ_W-1:0] irq_mask;

  // Read side snapshot taken at the setup edge
  reg                   cap_hit0;
  reg                   cap_hit1;
  reg                   cap_comp0;
  reg                   cap_comp1;

  // Combinational next values
  reg  [31:0]           next_rdata;
  reg                   next_err;
  reg                   ev0;
  reg                   ev1;
  reg                   next_start;
  reg                   next_stop;
  reg                   next_recording;

  // Bus phase and address decode
  wire                  setup_ph;
  wire                  access_ph;
  wire                  wr_take;
  wire                  rd_take;
  wire                  sel_c0;
  wire                  sel_c1;
  wire                  sel_trig;
  wire                  sel_mst;
  wire                  sel_ist;
  wire                  sel_imk;
  wire [`TWT_IRQ_W-1:0] irq_events;
  wire [`TWT_IRQ_W-1:0] irq_w1c;

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  // Zero wait states: read data was prepared at the setup edge
  assign pready_o  = access_ph;
  assign wr_take   = access_ph & pwrite_i;
  assign rd_take   = access_ph & ~pwrite_i;
  assign sel_c0    = ofs_match(paddr_i, `TWT_OFS_COMP0_CTRL);
  assign sel_c1    = ofs_match(paddr_i, `TWT_OFS_COMP1_CTRL);
  assign sel_trig  = ofs_match(paddr_i, `TWT_OFS_TRIG_CTRL);
  assign sel_mst   = ofs_match(paddr_i, `TWT_OFS_MASTER_CTRL);
  assign sel_ist   = ofs_match(paddr_i, `TWT_OFS_IRQ_STATUS);
  assign sel_imk   = ofs_match(paddr_i, `TWT_OFS_IRQ_MASK);

  // Comparator events and the pulses they raise
  always @*
  begin
    ev0 = 1'b0;
    if (access_valid_i & func_hit(fn0, access_fetch_i, access_read_i, access_write_i))
    begin
      if (!value_compare_on_o)
        ev0 = addr0_match_i;
      // Only bit 0 of the link field matters: two comparators exist
      else if (linked_address_comparator_o[0])
        ev0 = data0_match_i & addr1_match_i;
      else
        ev0 = data0_match_i;
    end
    // In linked use comp1 action is zero, so comp1 itself raises nothing
    ev1 = access_valid_i & addr1_match_i &
          func_hit(fn1, access_fetch_i, access_read_i, access_write_i);
    next_start = (ev0 & act0) | (ev1 & act1);
    next_stop  = (ev0 & ~act0) | (ev1 & ~act1);
  end

  // Read data captured in the setup phase, so the access phase answers at once
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (sel_c0)
    begin
      next_rdata[`TWT_FN_MSB:`TWT_FN_LSB]     = fn0;
      next_rdata[`TWT_VON_BIT]                = value_compare_on_o;
      next_rdata[`TWT_SIZE_MSB:`TWT_SIZE_LSB] = value_compare_size_o;
      next_rdata[`TWT_LINK_MSB:`TWT_LINK_LSB] = linked_address_comparator_o;
      next_rdata[`TWT_HIT_BIT]                = hit0;
    end
    else if (sel_c1)
    begin
      // Everything else stays zero: no value compare on comparator 1
      next_rdata[`TWT_FN_MSB:`TWT_FN_LSB] = fn1;
      next_rdata[`TWT_HIT_BIT]            = hit1;
    end
    else if (sel_trig)
    begin
      next_rdata[`TWT_NCOMP_MSB:`TWT_NCOMP_LSB] = `TWT_NCOMP_VAL;
      next_rdata[`TWT_ACT0_BIT]                 = act0;
      next_rdata[`TWT_ACT1_BIT]                 = act1;
    end
    else if (sel_mst)
    begin
      next_rdata[`TWT_STARTEN_BIT] = start_en;
      next_rdata[`TWT_STOPEN_BIT]  = stop_en;
      next_rdata[`TWT_REC_BIT]     = trace_recording_o;
    end
    else if (sel_ist)
      next_rdata[`TWT_IRQ_W-1:0] = irq_status;
    else if (sel_imk)
      next_rdata[`TWT_IRQ_W-1:0] = irq_mask;
    else
      next_err = 1'b1;
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= next_err;
    end
  end

  // What was shown decides what a read may clear
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cap_hit0  <= 1'b0;
      cap_hit1  <= 1'b0;
      cap_comp0 <= 1'b0;
      cap_comp1 <= 1'b0;
    end
    else if (setup_ph)
    begin
      cap_hit0  <= hit0;
      cap_hit1  <= hit1;
      cap_comp0 <= sel_c0;
      cap_comp1 <= sel_c1;
    end
  end

  // Hit flags: only the value actually returned is cleared; a new hit wins
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hit0 <= 1'b0;
      hit1 <= 1'b0;
    end
    else
    begin
      if (ev0)
        hit0 <= 1'b1;
      else if (rd_take & cap_comp0 & cap_hit0)
        hit0 <= 1'b0;
      if (ev1)
        hit1 <= 1'b1;
      else if (rd_take & cap_comp1 & cap_hit1)
        hit1 <= 1'b0;
    end
  end

  // Comparator control fields
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fn0                         <= `TWT_RST_FN;
      fn1                         <= `TWT_RST_FN;
      value_compare_on_o          <= 1'b0;
      value_compare_size_o        <= `TWT_RST_SIZE;
      linked_address_comparator_o <= `TWT_RST_LINK;
    end
    else if (wr_take)
    begin
      if (sel_c0)
      begin
        fn0                         <= pwdata_i[`TWT_FN_MSB:`TWT_FN_LSB];
        value_compare_on_o          <= pwdata_i[`TWT_VON_BIT];
        // Reserved size code passes through; the datapath owns its meaning
        value_compare_size_o        <= pwdata_i[`TWT_SIZE_MSB:`TWT_SIZE_LSB];
        linked_address_comparator_o <= pwdata_i[`TWT_LINK_MSB:`TWT_LINK_LSB];
      end
      // Only the action code is kept; the rest of the word is dropped
      if (sel_c1)
        fn1 <= pwdata_i[`TWT_FN_MSB:`TWT_FN_LSB];
    end
  end

  // Trigger actions, trace enables and interrupt mask
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      act0     <= 1'b0;
      act1     <= 1'b0;
      start_en <= 1'b0;
      stop_en  <= 1'b0;
      irq_mask <= `TWT_RST_IRQ;
    end
    else if (wr_take)
    begin
      if (sel_trig)
      begin
        act0 <= pwdata_i[`TWT_ACT0_BIT];
        act1 <= pwdata_i[`TWT_ACT1_BIT];
      end
      if (sel_mst)
      begin
        start_en <= pwdata_i[`TWT_STARTEN_BIT];
        stop_en  <= pwdata_i[`TWT_STOPEN_BIT];
      end
      if (sel_imk)
        irq_mask <= pwdata_i[`TWT_IRQ_W-1:0];
    end
  end

  // Start is tested first so it wins a tie; a disabled pulse is ignored
  always @*
  begin
    next_recording = trace_recording_o;
    if (trace_start_pulse_o & start_en)
      next_recording = 1'b1;
    else if (trace_stop_pulse_o & stop_en)
      next_recording = 1'b0;
  end

  // Trace pulses and recording state
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      trace_start_pulse_o <= 1'b0;
      trace_stop_pulse_o  <= 1'b0;
      trace_recording_o   <= 1'b0;
    end
    else
    begin
      trace_start_pulse_o <= next_start;
      trace_stop_pulse_o  <= next_stop;
      trace_recording_o   <= next_recording;
    end
  end

  // Sticky interrupt status, write one to clear, set beats clear
  assign irq_events = {trace_stop_pulse_o, trace_start_pulse_o, ev1, ev0};
  assign irq_w1c    = (wr_take & sel_ist) ? pwdata_i[`TWT_IRQ_W-1:0] : `TWT_RST_IRQ;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_status <= `TWT_RST_IRQ;
    else
      irq_status <= irq_events | (irq_status & ~irq_w1c);
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule // twt_trigger

/* verif/twt_core_model.sv */
`timescale 1ns/10ps
module twt_core_model
(
  // Request from the bench
  input  wire       clk_i,
  input  wire       go_i,
  input  wire [1:0] kind_i,
  input  wire [2:0] match_i,
  // Core access and comparator results
  output reg        access_valid_o = 1'b0,
  output reg  [2:0] access_type_o = 3'h0,
  output reg  [2:0] match_o = 3'h0
);
  always @(posedge clk_i)
  begin
    access_valid_o <= go_i;
    if (go_i)
    begin
      access_type_o <= {kind_i == 2'h3, kind_i == 2'h2, kind_i == 2'h1};
      match_o       <= match_i;
    end
    else
    begin
      // Idle lines toggle so an ungated qualifier shows up
      access_type_o <= ~access_type_o;
      match_o       <= ~match_o;
    end
  end
endmodule // twt_core_model

/* verif/twt_trigger_assertions.sv */
`timescale 1ns/10ps
module twt_trigger_assertions
(
  // Clock, reset, bus
  input wire        clk_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pslverr_o,
  // Events and trace control
  input wire        access_valid_i,
  input wire        addr0_match_i,
  input wire        data0_match_i,
  input wire        addr1_match_i,
  input wire        value_compare_on_o,
  input wire        trace_start_pulse_o,
  input wire        trace_stop_pulse_o,
  input wire        trace_recording_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire acc = psel_i && penable_i;
  wire rd  = acc && !pwrite_i;
  wire any = addr0_match_i || data0_match_i || addr1_match_i;
  wire map = paddr_i == 12'h028 || paddr_i == 12'h038 || paddr_i[11:4] == 8'h20;
  // Mirror of the start enable, so a disabled start may lose to a stop
  reg start_en_sh;
  always @(posedge clk_i or posedge reset_i)
    if (reset_i)
      start_en_sh <= 1'b0;
    else if (acc && pwrite_i && paddr_i == 12'h204)
      start_en_sh <= pwdata_i[0];
  a_unmapped_err: assert property (acc && !map |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_comp1_zero: assert property (rd && paddr_i == 12'h038 |->
    (prdata_o & 32'hfefffff0) == 0)
    else $error("comparator 1 fixed bits not zero");
  a_count_field: assert property (rd && paddr_i == 12'h200 |-> prdata_o[31:28] == 4'h2)
    else $error("comparator count wrong");
  a_start_cause: assert property (trace_start_pulse_o |-> $past(access_valid_i && any))
    else $error("start pulse without event");
  a_stop_cause: assert property (trace_stop_pulse_o |-> $past(access_valid_i && any))
    else $error("stop pulse without event");
  a_rise_start: assert property ($rose(trace_recording_o) |->
    $past(trace_start_pulse_o && start_en_sh))
    else $error("recording rose without start");
  a_fall_stop: assert property ($fell(trace_recording_o) |->
    $past(trace_stop_pulse_o) && !$past(trace_start_pulse_o && start_en_sh))
    else $error("recording fell without lone stop");
  a_von_hold: assert property (!$stable(value_compare_on_o) |->
    $past(acc && pwrite_i && paddr_i == 12'h028))
    else $error("compare mode changed without write");
  c_start: cover property (trace_start_pulse_o);
  c_stop: cover property (trace_stop_pulse_o);
  c_both: cover property (trace_start_pulse_o && trace_stop_pulse_o);
  c_err: cover property (acc && pslverr_o);
endmodule // twt_trigger_assertions
bind twt_trigger twt_trigger_assertions twt_trigger_assertions_inst (.clk_i, .reset_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .access_valid_i,
  .addr0_match_i, .data0_match_i, .addr1_match_i, .value_compare_on_o, .trace_start_pulse_o,
  .trace_stop_pulse_o, .trace_recording_o);

/* verif/twt_trigger_tb_top.sv */
`timescale 1ns/10ps
`include "twt_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module twt_trigger_tb_top;
  reg         clk, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
  reg  [11:0] pa = 0;
  reg  [31:0] pwd = 0, rd, r;
  reg  [1:0]  kind = 1, k, sz;
  reg  [2:0]  mv = 0, m;
  reg  [3:0]  f, f1;
  reg         er, v, l, a0, a1, se, te, rc = 0, p0, p1, st, sp;
  wire        rdy, serr, irq, av, von, tsp, tpp, rec;
  wire [2:0]  at, mt;
  wire [31:0] prd;
  wire [1:0]  szo;
  wire [3:0]  lnk;
  integer     errors = 0, total_checks = 0, seed = 73, i, n;
  twt_core_model twt_core_model_inst (.clk_i(clk), .go_i(go), .kind_i(kind), .match_i(mv),
    .access_valid_o(av), .access_type_o(at), .match_o(mt));
  twt_trigger twt_trigger_inst (.clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(rdy), .prdata_o(prd),
    .pslverr_o(serr), .access_valid_i(av), .access_fetch_i(at[0]), .access_read_i(at[1]),
    .access_write_i(at[2]), .addr0_match_i(mt[0]), .data0_match_i(mt[1]),
    .addr1_match_i(mt[2]), .value_compare_on_o(von), .value_compare_size_o(szo),
    .linked_address_comparator_o(lnk), .trace_start_pulse_o(tsp), .trace_stop_pulse_o(tpp),
    .trace_recording_o(rec), .irq_o(irq));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task results;
    begin
      if (errors == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1;
      pen  <= 0;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1)
      begin
        errors++;
        results;
      end
      rd = prd;
      er = serr;
      psel <= 0;
      pen  <= 0;
      #1;
    end
  endtask
  task access(input [1:0] kk, input [2:0] mm);
    begin
      @(posedge clk);
      go   <= 1;
      kind <= kk;
      mv   <= mm;
      @(posedge clk);
      go <= 0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  function h(input [3:0] fn, input [1:0] kk);
    h = (fn == `TWT_FN_FETCH && kk == 1) || (fn == `TWT_FN_READ && kk == 2) ||
        (fn == `TWT_FN_WRITE && kk == 3) || (fn == `TWT_FN_RW && kk[1]);
  endfunction
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    apb(1, `TWT_OFS_COMP1_CTRL, 32'hfffffff0); // Only listed codes used
    apb(0, `TWT_OFS_COMP1_CTRL, 0);
    `CHK(rd, 32'h0)
    apb(0, `TWT_OFS_TRIG_CTRL, 0);
    `CHK(rd[31:28], `TWT_NCOMP_VAL)
    apb(1, 12'h100, 1);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1, `TWT_OFS_COMP1_CTRL, `TWT_FN_FETCH);
    access(1, 3'h4);
    apb(0, `TWT_OFS_IRQ_STATUS, 0);
    `CHK({rd[1], irq}, 2'h2)
    apb(1, `TWT_OFS_IRQ_MASK, 2);
    `CHK(irq, 1'b1)
    apb(1, `TWT_OFS_IRQ_STATUS, 32'hf);
    `CHK(irq, 1'b0)
    apb(0, `TWT_OFS_COMP1_CTRL, 0);
    for (i = 0; i < 24; i++)
    begin
      r  = $random(seed);
      f  = r[2] ? {2'h1, r[1:0]} : 4'h0;
      k  = {r[16:15]} % 3 + 1;
      {v, l, a0, a1, se, te, m, sz} = r[13:3];
      if (sz == 3)
        sz = 2;
      if (i == 0)
        {f, k, v, a0, a1, se, m} = {`TWT_FN_FETCH, 2'h1, 1'b0, 2'h1, 1'b1, 3'h7};
      f1 = (v && l) ? 4'h0 : f; // Linked pair keeps comparator 1 off
      apb(1, `TWT_OFS_MASTER_CTRL, {te, se});
      apb(1, `TWT_OFS_TRIG_CTRL, {a1, a0});
      apb(1, `TWT_OFS_COMP0_CTRL, {3'h0, l, sz, 1'b0, v, 4'h0, f}); // Link 0 or 1 only
      apb(1, `TWT_OFS_COMP1_CTRL, f1);
      `CHK({von, szo, lnk}, {v, sz, 3'h0, l})
      access(k, m);
      p0 = h(f, k) && (v ? m[1] && (!l || m[2]) : m[0]);
      p1 = h(f1, k) && m[2];
      st = (p0 && a0) || (p1 && a1);
      sp = (p0 && !a0) || (p1 && !a1);
      if (st && se)
        rc = 1;
      else if (sp && te)
        rc = 0;
      apb(0, `TWT_OFS_COMP0_CTRL, 0);
      `CHK(rd, {7'h0, p0, 8'h0, 3'h0, l, sz, 1'b0, v, 4'h0, f})
      apb(0, `TWT_OFS_COMP0_CTRL, 0);
      `CHK(rd[24], 1'b0)
      apb(0, `TWT_OFS_COMP1_CTRL, 0);
      `CHK(rd, {7'h0, p1, 20'h0, f1})
      apb(0, `TWT_OFS_MASTER_CTRL, 0);
      `CHK({rec, rd[2]}, {rc, rc})
      apb(0, `TWT_OFS_IRQ_STATUS, 0);
      `CHK({rd[3:0], irq}, {sp, st, p1, p0, p1})
      apb(1, `TWT_OFS_IRQ_STATUS, 32'hf);
    end
    results;
  end
endmodule // twt_trigger_tb_top
